// >>> hdl/afk_top.sv
// Frame type classifier and per-port lookup key selector with register port
`timescale 1ns/1ps
`include "afk_regs.svh"

module afk_top
  import afk_pkg::*;
#(
  parameter int NUM_PORTS   = 8,
  parameter int NUM_LOOKUPS = 2,
  parameter int PORT_W      = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1
)
(
  input  wire logic                                clock,
  input  wire logic                                rst,
  // Register port
  input  wire logic [7:0]                          reg_addr,
  input  wire logic [31:0]                         reg_wdata,
  input  wire logic                                reg_we,
  input  wire logic                                reg_re,
  output logic      [31:0]                         reg_rdata,
  // Parsed frame in
  input  wire logic                                frm_valid,
  input  wire logic [PORT_W-1:0]                   frm_port,
  input  wire logic [15:0]                         frm_ethertype,
  input  wire logic [3:0]                          frm_ip_version,
  input  wire logic [7:0]                          frm_ip_dst_top,
  input  wire logic [7:0]                          frm_ip_proto,
  input  wire logic [7:0]                          frm_llc_dsap,
  input  wire logic [7:0]                          frm_llc_ssap,
  input  wire logic [7:0]                          frm_llc_ctrl,
  input  wire logic                                frm_custom_req,
  input  wire logic [7:0]                          frm_custom_offset,
  // Key selection out
  output logic                                     key_valid,
  output logic      [PORT_W-1:0]                   key_port,
  output logic      [NUM_LOOKUPS-1:0]              lookup_en,
  output afk_pkg::afk_key_t [NUM_LOOKUPS-1:0]      key_type,
  output afk_pkg::afk_ftype_t                      frame_type,
  output afk_pkg::afk_l4_t                         l4_class,
  output logic                                     custom_use,
  output logic      [7:0]                          custom_offset
);

  import afk_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int CFG_W = `AFK_CFG_W;
  localparam int CFG_N = NUM_PORTS * NUM_LOOKUPS;

  typedef struct packed {
    logic [CFG_N-1:0][CFG_W-1:0]   cfg;
    logic [31:0]                   rdata;
    logic                          kvalid;
    logic [PORT_W-1:0]             port;
    logic [NUM_LOOKUPS-1:0]        en;
    afk_key_t [NUM_LOOKUPS-1:0]    key;
    afk_ftype_t                    ftype;
    afk_l4_t                       l4;
    logic                          custom;
    logic [7:0]                    coffset;
    logic [31:0]                   count;
  } afk_state_t;

  afk_state_t                      s;
  afk_state_t                      next_s;
  afk_ftype_t                      cls_ftype;
  afk_l4_t                         cls_l4;
  logic [NUM_LOOKUPS-1:0][CFG_W-1:0] frm_cfg;
  afk_key_t [NUM_LOOKUPS-1:0]      pick_key;
  logic                            port_ok;
  logic                            addr_is_cfg;
  int                              addr_idx;

  // Configuration slot of a port and lookup
  function automatic int cfg_index(input int port, input int lk);
    return port * NUM_LOOKUPS + lk;
  endfunction

  // ----------------------------------------------------------------
  // Classification and key choice
  // ----------------------------------------------------------------
  afk_frame_classify u_classify (
    .ethertype  (frm_ethertype),
    .ip_version (frm_ip_version),
    .ip_dst_top (frm_ip_dst_top),
    .ip_proto   (frm_ip_proto),
    .llc_dsap   (frm_llc_dsap),
    .llc_ssap   (frm_llc_ssap),
    .llc_ctrl   (frm_llc_ctrl),
    .frame_type (cls_ftype),
    .l4_class   (cls_l4)
  );

  // Per-lookup setting of the ingress port, zero for a bad port
  assign port_ok = int'(frm_port) < NUM_PORTS;

  always_comb
  begin
    for (int l = 0; l < NUM_LOOKUPS; l++)
    begin
      if (port_ok)
        frm_cfg[l] = s.cfg[cfg_index(int'(frm_port), l)];
      else
        frm_cfg[l] = `AFK_CFG_RST;
    end
  end

  // One key chooser per lookup
  for (genvar g = 0; g < NUM_LOOKUPS; g++)
  begin : g_pick
    afk_key_pick u_pick (
      .frame_type (cls_ftype),
      .l4_class   (cls_l4),
      .cfg        (frm_cfg[g]),
      .custom_req (frm_custom_req),
      .key        (pick_key[g])
    );
  end

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  assign addr_idx    = int'(reg_addr) - int'(`AFK_CFG_BASE);
  assign addr_is_cfg = (addr_idx >= 0) && (addr_idx < CFG_N);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    // Config writes, unmapped writes ignored
    if (reg_we && addr_is_cfg)
      next_s.cfg[addr_idx] = reg_wdata[CFG_W-1:0];
    // Read data stands one cycle only
    next_s.rdata = '0;
    if (reg_re)
    begin
      if (addr_is_cfg)
        next_s.rdata = 32'(s.cfg[addr_idx]);
      else if (reg_addr == `AFK_STAT_LAST)
      begin
        next_s.rdata[`AFK_ST_FT_LO +: 4]   = s.ftype;
        next_s.rdata[`AFK_ST_L4_LO +: 2]   = s.l4;
        next_s.rdata[`AFK_ST_KEY0_LO +: 4] = s.key[0];
        if (NUM_LOOKUPS > 1)
          next_s.rdata[`AFK_ST_KEY1_LO +: 4] = s.key[NUM_LOOKUPS-1];
      end
      else if (reg_addr == `AFK_STAT_COUNT)
        next_s.rdata = s.count;
    end
    // Registered result, one cycle after the frame
    next_s.kvalid = frm_valid;
    if (frm_valid)
    begin
      next_s.port    = frm_port;
      next_s.ftype   = cls_ftype;
      next_s.l4      = cls_l4;
      next_s.key     = pick_key;
      next_s.custom  = frm_custom_req;
      next_s.coffset = frm_custom_offset;
      next_s.count   = s.count + 32'h1;
      for (int l = 0; l < NUM_LOOKUPS; l++)
        next_s.en[l] = frm_cfg[l][`AFK_F_EN];
    end
  end

  // State register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata     = s.rdata;
  assign key_valid     = s.kvalid;
  assign key_port      = s.port;
  assign lookup_en     = s.en;
  assign key_type      = s.key;
  assign frame_type    = s.ftype;
  assign l4_class      = s.l4;
  assign custom_use    = s.custom;
  assign custom_offset = s.coffset;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_cfg_off0;
    reg_we && reg_addr == `AFK_CFG_BASE && !reg_wdata[`AFK_F_EN];
  endsequence

  sequence s_port0_frame;
    frm_valid && frm_port == '0 && !reg_we;
  endsequence

  a_key_follows_frame: assert property (
    frm_valid |=> key_valid ##1 (key_valid == $past(frm_valid)))
    else $error("result does not follow frame");

  a_no_spurious_key: assert property (
    !frm_valid |=> !key_valid && $stable(frame_type))
    else $error("result without frame");

  a_ipv6_type: assert property (
    frm_valid && frm_ethertype == `AFK_ET_IPV6 && frm_ip_version == `AFK_IPVER6
    |=> frame_type == (($past(frm_ip_dst_top) == `AFK_V6_MC_PFX)
                       ? AFK_FT_IPV6_MC : AFK_FT_IPV6_UC))
    else $error("ipv6 type wrong");

  a_ipv4_type: assert property (
    frm_valid && frm_ethertype == `AFK_ET_IPV4 && frm_ip_version == `AFK_IPVER4
    |=> frame_type == (($past(frm_ip_dst_top[7:4]) == `AFK_V4_MC_PFX)
                       ? AFK_FT_IPV4_MC : AFK_FT_IPV4_UC))
    else $error("ipv4 type wrong");

  a_ip_transport: assert property (
    key_valid && frame_type inside {AFK_FT_IPV6_MC, AFK_FT_IPV6_UC,
                                    AFK_FT_IPV4_MC, AFK_FT_IPV4_UC}
    |-> l4_class == (($past(frm_ip_proto) == `AFK_PROTO_TCP) ? AFK_L4_TCP :
                     ($past(frm_ip_proto) == `AFK_PROTO_UDP) ? AFK_L4_UDP : AFK_L4_OTHER))
    else $error("transport class wrong");

  a_arp_oam_type: assert property (
    frm_valid && (frm_ethertype == `AFK_ET_ARP || frm_ethertype == `AFK_ET_RARP
                  || frm_ethertype == `AFK_ET_OAM)
    |=> frame_type == (($past(frm_ethertype) == `AFK_ET_OAM) ? AFK_FT_OAM : AFK_FT_ARP))
    else $error("arp or oam type wrong");

  a_llc_snap_type: assert property (
    frm_valid && frm_ethertype < `AFK_ET_MIN
    |=> frame_type == (($past(frm_llc_dsap) == `AFK_SAP_SNAP
                        && $past(frm_llc_ssap) == `AFK_SAP_SNAP
                        && $past(frm_llc_ctrl) == `AFK_CTRL_UI) ? AFK_FT_SNAP : AFK_FT_LLC))
    else $error("llc or snap type wrong");

  a_etype_fallback: assert property (
    key_valid && frame_type == AFK_FT_ETYPE
    |-> $past(frm_ethertype) >= `AFK_ET_MIN && $past(frm_ethertype) != `AFK_ET_ARP
        && $past(frm_ethertype) != `AFK_ET_RARP && $past(frm_ethertype) != `AFK_ET_OAM)
    else $error("generic type on specific frame");

  a_lookup_off: assert property (
    s_cfg_off0 ##1 s_port0_frame |=> !lookup_en[0] && key_type[0] == AFK_KEY_NONE)
    else $error("disabled lookup built a key");

  a_generic_forced: assert property (
    key_valid && lookup_en[0] && !custom_use
    && frame_type inside {AFK_FT_OAM, AFK_FT_SNAP, AFK_FT_LLC, AFK_FT_ETYPE}
    |-> key_type[0] == AFK_KEY_GENERIC_MAC)
    else $error("generic key not forced");

  a_allowed_keys: assert property (
    key_valid && lookup_en[0] && !custom_use && frame_type == AFK_FT_IPV6_UC
    |-> key_type[0] inside {AFK_KEY_SEVEN_TUPLE, AFK_KEY_GENERIC_MAC})
    else $error("key not allowed for ipv6 unicast");

  a_custom_wins: assert property (
    key_valid && custom_use && lookup_en[0] |-> key_type[0] == AFK_KEY_CUSTOM)
    else $error("custom request not honoured");

  a_result_copies: assert property (
    frm_valid |=> key_port == $past(frm_port) && custom_use == $past(frm_custom_req)
                  && custom_offset == $past(frm_custom_offset))
    else $error("frame copies not registered");

  a_bad_port_off: assert property (
    frm_valid && !port_ok |=> lookup_en == '0 && key_type == '0)
    else $error("out of range port built a key");

  a_disabled_none: assert property (
    key_valid && !lookup_en[NUM_LOOKUPS-1] |-> key_type[NUM_LOOKUPS-1] == AFK_KEY_NONE)
    else $error("disabled lookup kept a key");

  a_generic_forced_hi: assert property (
    key_valid && lookup_en[NUM_LOOKUPS-1] && !custom_use
    && frame_type inside {AFK_FT_OAM, AFK_FT_SNAP, AFK_FT_LLC, AFK_FT_ETYPE}
    |-> key_type[NUM_LOOKUPS-1] == AFK_KEY_GENERIC_MAC)
    else $error("generic key not forced on last lookup");

  a_arp_keys: assert property (
    key_valid && lookup_en[0] && !custom_use && frame_type == AFK_FT_ARP
    |-> key_type[0] inside {AFK_KEY_ARP, AFK_KEY_GENERIC_MAC})
    else $error("key not allowed for address resolution");

  a_ipv4_uc_keys: assert property (
    key_valid && lookup_en[0] && !custom_use && frame_type == AFK_FT_IPV4_UC
    |-> key_type[0] inside {AFK_KEY_SEVEN_TUPLE, AFK_KEY_IPV4_TRANS,
                            AFK_KEY_IPV4_MISC, AFK_KEY_GENERIC_MAC})
    else $error("key not allowed for ipv4 unicast");

  a_ipv4_mc_keys: assert property (
    key_valid && lookup_en[0] && !custom_use && frame_type == AFK_FT_IPV4_MC
    |-> key_type[0] inside {AFK_KEY_IPV4_VLAN, AFK_KEY_SEVEN_TUPLE, AFK_KEY_IPV4_TRANS,
                            AFK_KEY_IPV4_MISC, AFK_KEY_GENERIC_MAC})
    else $error("key not allowed for ipv4 multicast");

  a_ipv6_mc_keys: assert property (
    key_valid && lookup_en[0] && !custom_use && frame_type == AFK_FT_IPV6_MC
    |-> key_type[0] inside {AFK_KEY_IPV6_VLAN, AFK_KEY_SEVEN_TUPLE, AFK_KEY_GENERIC_MAC})
    else $error("key not allowed for ipv6 multicast");

  a_rdata_one_cycle: assert property (
    !reg_re |=> reg_rdata == 32'h0)
    else $error("read data outside read slot");

endmodule

// >>> hdl/afk_regs.svh
// Constants for the frame type and key select block: codes, offsets, field positions
`ifndef AFK_REGS_SVH
`define AFK_REGS_SVH

// ----------------------------------------------------------------
// Frame header codes
// ----------------------------------------------------------------
`define AFK_ET_IPV6      16'h86dd
`define AFK_ET_IPV4      16'h0800
`define AFK_ET_ARP       16'h0806
`define AFK_ET_RARP      16'h8035
`define AFK_ET_OAM       16'h8902
`define AFK_ET_MIN       16'h0600
`define AFK_IPVER6       4'h6
`define AFK_IPVER4       4'h4
`define AFK_V6_MC_PFX    8'hff
`define AFK_V4_MC_PFX    4'he
`define AFK_PROTO_TCP    8'h06
`define AFK_PROTO_UDP    8'h11
`define AFK_SAP_SNAP     8'haa
`define AFK_CTRL_UI      8'h03

// ----------------------------------------------------------------
// Register offsets (word addresses)
// ----------------------------------------------------------------
`define AFK_CFG_BASE     8'h00
`define AFK_STAT_LAST    8'h80
`define AFK_STAT_COUNT   8'h81

// ----------------------------------------------------------------
// Lookup configuration word layout
// ----------------------------------------------------------------
`define AFK_CFG_W        9
`define AFK_CFG_RST      9'h000
`define AFK_F_EN         0
`define AFK_F_V6MC_LO    1
`define AFK_F_V6MC_HI    2
`define AFK_F_V6UC       3
`define AFK_F_V4MC_LO    4
`define AFK_F_V4MC_HI    5
`define AFK_F_V4UC_LO    6
`define AFK_F_V4UC_HI    7
`define AFK_F_ARP        8

// ----------------------------------------------------------------
// Selection codes per frame class
// ----------------------------------------------------------------
`define AFK_SEL_V6MC_VLAN  2'h0
`define AFK_SEL_V6MC_SEVEN 2'h1
`define AFK_SEL_V6UC_SEVEN 1'h0
`define AFK_SEL_V4MC_VLAN  2'h0
`define AFK_SEL_V4MC_SEVEN 2'h1
`define AFK_SEL_V4MC_L4    2'h2
`define AFK_SEL_V4UC_SEVEN 2'h0
`define AFK_SEL_V4UC_L4    2'h1
`define AFK_SEL_ARP_ARP    1'h0

// ----------------------------------------------------------------
// Status word layout
// ----------------------------------------------------------------
`define AFK_ST_FT_LO     0
`define AFK_ST_L4_LO     4
`define AFK_ST_KEY0_LO   8
`define AFK_ST_KEY1_LO   12

`endif

// >>> hdl/afk_pkg.sv
// Types shared by the frame type and key select block
package afk_pkg;

  // Nine frame types
  typedef enum logic [3:0] {
    AFK_FT_IPV6_MC = 4'h0,
    AFK_FT_IPV6_UC = 4'h1,
    AFK_FT_IPV4_MC = 4'h2,
    AFK_FT_IPV4_UC = 4'h3,
    AFK_FT_ARP     = 4'h4,
    AFK_FT_OAM     = 4'h5,
    AFK_FT_SNAP    = 4'h6,
    AFK_FT_LLC     = 4'h7,
    AFK_FT_ETYPE   = 4'h8
  } afk_ftype_t;

  // Transport class of IP frames
  typedef enum logic [1:0] {
    AFK_L4_OTHER = 2'h0,
    AFK_L4_TCP   = 2'h1,
    AFK_L4_UDP   = 2'h2
  } afk_l4_t;

  // Key types handed to the lookup
  typedef enum logic [3:0] {
    AFK_KEY_NONE        = 4'h0,
    AFK_KEY_GENERIC_MAC = 4'h1,
    AFK_KEY_IPV6_VLAN   = 4'h2,
    AFK_KEY_IPV4_VLAN   = 4'h3,
    AFK_KEY_SEVEN_TUPLE = 4'h4,
    AFK_KEY_IPV4_TRANS  = 4'h5,
    AFK_KEY_IPV4_MISC   = 4'h6,
    AFK_KEY_ARP         = 4'h7,
    AFK_KEY_CUSTOM      = 4'h8
  } afk_key_t;

endpackage

// >>> hdl/afk_frame_classify.sv
// Combinational frame type and transport classifier
`timescale 1ns/1ps
`include "afk_regs.svh"

module afk_frame_classify
  import afk_pkg::*;
(
  input  wire logic [15:0]       ethertype,
  input  wire logic [3:0]        ip_version,
  input  wire logic [7:0]        ip_dst_top,
  input  wire logic [7:0]        ip_proto,
  input  wire logic [7:0]        llc_dsap,
  input  wire logic [7:0]        llc_ssap,
  input  wire logic [7:0]        llc_ctrl,
  output afk_pkg::afk_ftype_t    frame_type,
  output afk_pkg::afk_l4_t       l4_class
);

  // Priority chain gives exactly one type, ethertype as fallback
  always_comb
  begin
    if (ethertype == `AFK_ET_IPV6 && ip_version == `AFK_IPVER6)
      frame_type = (ip_dst_top == `AFK_V6_MC_PFX) ? AFK_FT_IPV6_MC : AFK_FT_IPV6_UC;
    else if (ethertype == `AFK_ET_IPV4 && ip_version == `AFK_IPVER4)
      frame_type = (ip_dst_top[7:4] == `AFK_V4_MC_PFX) ? AFK_FT_IPV4_MC : AFK_FT_IPV4_UC;
    else if (ethertype == `AFK_ET_ARP || ethertype == `AFK_ET_RARP)
      frame_type = AFK_FT_ARP;
    else if (ethertype == `AFK_ET_OAM)
      frame_type = AFK_FT_OAM;
    else if (ethertype < `AFK_ET_MIN)
    begin
      if (llc_dsap == `AFK_SAP_SNAP && llc_ssap == `AFK_SAP_SNAP && llc_ctrl == `AFK_CTRL_UI)
        frame_type = AFK_FT_SNAP;
      else
        frame_type = AFK_FT_LLC;
    end
    else
      frame_type = AFK_FT_ETYPE;
  end

  // Transport class for both IP versions
  always_comb
  begin
    l4_class = AFK_L4_OTHER;
    if (frame_type inside {AFK_FT_IPV6_MC, AFK_FT_IPV6_UC, AFK_FT_IPV4_MC, AFK_FT_IPV4_UC})
    begin
      if (ip_proto == `AFK_PROTO_TCP)
        l4_class = AFK_L4_TCP;
      else if (ip_proto == `AFK_PROTO_UDP)
        l4_class = AFK_L4_UDP;
    end
  end

endmodule

// >>> hdl/afk_key_pick.sv
// Combinational key type choice for one lookup
`timescale 1ns/1ps
`include "afk_regs.svh"

module afk_key_pick
  import afk_pkg::*;
(
  input  afk_pkg::afk_ftype_t        frame_type,
  input  afk_pkg::afk_l4_t           l4_class,
  input  wire logic [`AFK_CFG_W-1:0] cfg,
  input  wire logic                  custom_req,
  output afk_pkg::afk_key_t          key
);

  // Transport or misc key for IPv4, by transport class
  function automatic afk_key_t ip4_l4_key(input afk_l4_t l4);
    return (l4 == AFK_L4_OTHER) ? AFK_KEY_IPV4_MISC : AFK_KEY_IPV4_TRANS;
  endfunction

  // Enable gate, custom override, then per-type selection
  always_comb
  begin
    key = AFK_KEY_GENERIC_MAC;
    if (!cfg[`AFK_F_EN])
      key = AFK_KEY_NONE;
    else if (custom_req)
      key = AFK_KEY_CUSTOM;
    else
    begin
      unique case (frame_type)
        AFK_FT_IPV6_MC:
          if (cfg[`AFK_F_V6MC_HI:`AFK_F_V6MC_LO] == `AFK_SEL_V6MC_VLAN)
            key = AFK_KEY_IPV6_VLAN;
          else if (cfg[`AFK_F_V6MC_HI:`AFK_F_V6MC_LO] == `AFK_SEL_V6MC_SEVEN)
            key = AFK_KEY_SEVEN_TUPLE;
        AFK_FT_IPV6_UC:
          if (cfg[`AFK_F_V6UC] == `AFK_SEL_V6UC_SEVEN)
            key = AFK_KEY_SEVEN_TUPLE;
        AFK_FT_IPV4_MC:
          if (cfg[`AFK_F_V4MC_HI:`AFK_F_V4MC_LO] == `AFK_SEL_V4MC_VLAN)
            key = AFK_KEY_IPV4_VLAN;
          else if (cfg[`AFK_F_V4MC_HI:`AFK_F_V4MC_LO] == `AFK_SEL_V4MC_SEVEN)
            key = AFK_KEY_SEVEN_TUPLE;
          else if (cfg[`AFK_F_V4MC_HI:`AFK_F_V4MC_LO] == `AFK_SEL_V4MC_L4)
            key = ip4_l4_key(l4_class);
        AFK_FT_IPV4_UC:
          if (cfg[`AFK_F_V4UC_HI:`AFK_F_V4UC_LO] == `AFK_SEL_V4UC_SEVEN)
            key = AFK_KEY_SEVEN_TUPLE;
          else if (cfg[`AFK_F_V4UC_HI:`AFK_F_V4UC_LO] == `AFK_SEL_V4UC_L4)
            key = ip4_l4_key(l4_class);
        AFK_FT_ARP:
          if (cfg[`AFK_F_ARP] == `AFK_SEL_ARP_ARP)
            key = AFK_KEY_ARP;
        default:
          key = AFK_KEY_GENERIC_MAC;
      endcase
    end
  end

endmodule

// >>> dv/afk_parser_model.sv
// Upstream parser model that hands frame descriptors to the block
`timescale 1ns/1ps

module afk_parser_model
(
  input  wire logic        clock,
  output logic             frm_valid,
  output logic [2:0]       frm_port,
  output logic [59:0]      hdr,
  output logic             frm_custom_req,
  output logic [7:0]       frm_custom_offset
);
  // Quiet start before the first descriptor
  initial
  begin
    frm_valid = 1'b0;
    frm_port = 3'h0;
    hdr = 60'h0;
    frm_custom_req = 1'b0;
    frm_custom_offset = 8'h0;
  end

  // One-cycle descriptor, then fields flip so stale data never looks valid
  task automatic send(input logic [2:0] p, input logic [59:0] h, input logic c,
                      input logic [7:0] o);
    @(posedge clock);
    frm_valid <= 1'b1;
    frm_port <= p;
    hdr <= h;
    frm_custom_req <= c;
    frm_custom_offset <= o;
    @(posedge clock);
    frm_valid <= 1'b0;
    frm_port <= ~p;
    hdr <= ~h;
    frm_custom_req <= ~c;
    frm_custom_offset <= ~o;
  endtask
endmodule

// >>> dv/afk_top_tb.sv
// Self-checking bench for the frame type and key select block
`timescale 1ns/1ps
`include "afk_regs.svh"

module afk_top_tb;
  import afk_pkg::*;

  logic              clock = 1'b0;
  logic              rst = 1'b1;
  logic [7:0]        reg_addr = 8'h0;
  logic [31:0]       reg_wdata = 32'h0;
  logic              reg_we = 1'b0;
  logic              reg_re = 1'b0;
  logic [31:0]       reg_rdata;
  logic              frm_valid;
  logic [2:0]        frm_port;
  logic [59:0]       hdr;
  logic              frm_custom_req;
  logic [7:0]        frm_custom_offset;
  logic              key_valid;
  logic [2:0]        key_port;
  logic [1:0]        lookup_en;
  afk_key_t [1:0]    key_type;
  afk_ftype_t        frame_type;
  afk_l4_t           l4_class;
  logic              custom_use;
  logic [7:0]        custom_offset;
  logic [8:0]        cfg [0:7];
  logic [59:0]       hd [0:10];
  logic [5:0]        ex [0:10];
  int                err_total = 0;
  int                checks = 0;

  // ----------------------------------------------------------------
  // Clock, parts and verdict
  // ----------------------------------------------------------------
  initial
  begin
    forever #20 clock = ~clock;
  end

  afk_parser_model src (.clock(clock), .frm_valid(frm_valid), .frm_port(frm_port),
    .hdr(hdr), .frm_custom_req(frm_custom_req), .frm_custom_offset(frm_custom_offset));

  afk_top #(.NUM_PORTS(6), .NUM_LOOKUPS(2)) uut (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .frm_valid(frm_valid), .frm_port(frm_port),
    .frm_ethertype(hdr[59:44]), .frm_ip_version(hdr[43:40]),
    .frm_ip_dst_top(hdr[39:32]), .frm_ip_proto(hdr[31:24]),
    .frm_llc_dsap(hdr[23:16]), .frm_llc_ssap(hdr[15:8]), .frm_llc_ctrl(hdr[7:0]),
    .frm_custom_req(frm_custom_req), .frm_custom_offset(frm_custom_offset),
    .key_valid(key_valid), .key_port(key_port), .lookup_en(lookup_en),
    .key_type(key_type), .frame_type(frame_type), .l4_class(l4_class),
    .custom_use(custom_use), .custom_offset(custom_offset));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (err_total == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clock);
    err_total++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Register port and expected key
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clock);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clock);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Allowed key per frame class under a selection word
  function automatic afk_key_t exp_key(afk_ftype_t f, afk_l4_t l, logic [8:0] c,
                                       logic cr);
    afk_key_t g;
    afk_key_t t;
    g = AFK_KEY_GENERIC_MAC;
    t = (l == AFK_L4_OTHER) ? AFK_KEY_IPV4_MISC : AFK_KEY_IPV4_TRANS;
    if (!c[0])
      return AFK_KEY_NONE;
    if (cr)
      return AFK_KEY_CUSTOM;
    case (f)
      AFK_FT_IPV6_MC: return (c[2:1] == 2'h0) ? AFK_KEY_IPV6_VLAN :
                             (c[2:1] == 2'h1) ? AFK_KEY_SEVEN_TUPLE : g;
      AFK_FT_IPV6_UC: return c[3] ? g : AFK_KEY_SEVEN_TUPLE;
      AFK_FT_IPV4_MC: return (c[5:4] == 2'h0) ? AFK_KEY_IPV4_VLAN :
                             (c[5:4] == 2'h1) ? AFK_KEY_SEVEN_TUPLE :
                             (c[5:4] == 2'h2) ? t : g;
      AFK_FT_IPV4_UC: return (c[7:6] == 2'h0) ? AFK_KEY_SEVEN_TUPLE :
                             (c[7:6] == 2'h1) ? t : g;
      AFK_FT_ARP:     return c[8] ? g : AFK_KEY_ARP;
      default:        return g;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset value, readback, status write and unmapped read
  task automatic t_regs;
    logic [31:0] d;
    rd(`AFK_CFG_BASE, d);
    chk(d, 32'h0);
    for (int a = 0; a < 6; a++)
      wr(a[7:0], 32'hfffffe00 | 32'(cfg[a]));
    wr(`AFK_STAT_COUNT, 32'h55);
    for (int a = 0; a < 6; a++)
    begin
      rd(a[7:0], d);
      chk(d, 32'(cfg[a]));
    end
    rd(8'h40, d);
    chk(d, 32'h0);
  endtask

  // Every frame class on enabled, mixed, disabled and out-of-range ports
  task automatic t_types(input logic [2:0] p, input logic cr);
    logic [8:0] c0;
    logic [8:0] c1;
    c0 = (p < 6) ? cfg[2 * p] : 9'h0;
    c1 = (p < 6) ? cfg[2 * p + 1] : 9'h0;
    for (int i = 0; i < 11; i++)
    begin
      src.send(p, hd[i], cr, 8'h5a ^ i[7:0]);
      #1;
      chk(key_valid, 1'b1);
      chk(key_port, p);
      chk(frame_type, ex[i][5:2]);
      chk(l4_class, ex[i][1:0]);
      chk(lookup_en, {c1[0], c0[0]});
      chk(key_type[0], exp_key(afk_ftype_t'(ex[i][5:2]), afk_l4_t'(ex[i][1:0]), c0, cr));
      chk(key_type[1], exp_key(afk_ftype_t'(ex[i][5:2]), afk_l4_t'(ex[i][1:0]), c1, cr));
      chk(custom_use, cr);
      chk(custom_offset, 8'h5a ^ i[7:0]);
    end
  endtask

  // Status word and frame counter after the t_types runs, before t_disable
  task automatic t_status;
    logic [31:0] d;
    rd(`AFK_STAT_LAST, d);
    chk(d, 32'h00008808);
    rd(`AFK_STAT_COUNT, d);
    chk(d, 32'd77);
  endtask

  // Lookup switched off by a write one cycle before a frame on that port
  task automatic t_disable;
    fork
      wr(`AFK_CFG_BASE, 32'h000001fe);
      begin
        @(posedge clock);
        src.send(3'h0, hd[0], 1'b0, 8'h00);
      end
    join
    #1;
    chk(lookup_en, {cfg[1][0], 1'b0});
    chk(key_type[0], AFK_KEY_NONE);
    chk(key_type[1], exp_key(AFK_FT_IPV6_MC, AFK_L4_TCP, cfg[1], 1'b0));
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    cfg = '{9'h001, 9'h1ff, 9'h063, 9'h0a9, 9'h000, 9'h000, 9'h000, 9'h000};
    hd = '{60'h86dd6ff06000000, 60'h86dd6fe11000000, 60'h08004e011000000,
           60'h08004df01000000, 60'h08064e006000000, 60'h803500000000000,
           60'h890200000000000, 60'h05ff00000aaaa03, 60'h05ff00000aaaa02,
           60'h86dd4ff06000000, 60'h060000000aaaa03};
    ex = '{6'h01, 6'h06, 6'h0a, 6'h0c, 6'h10, 6'h10, 6'h14, 6'h18, 6'h1c, 6'h20, 6'h20};
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_types(3'h0, 1'b0);
    t_types(3'h1, 1'b0);
    t_types(3'h2, 1'b0);
    t_types(3'h7, 1'b0);
    t_types(3'h2, 1'b1);
    t_types(3'h1, 1'b1);
    t_types(3'h0, 1'b1);
    t_status();
    t_disable();
    wrap_up();
  end
endmodule
